// ===== verilog/kpe_pkg.sv
// shared constants of the keypad event encoder
package kpe_pkg;
	// matrix and line geometry
	localparam int unsigned ROWS = 8;
	localparam int unsigned COLS = 10;
	localparam int unsigned LINES = ROWS + COLS;
	localparam int unsigned KEYS = ROWS * COLS;
	localparam int unsigned COL_LINE_BASE = ROWS;
	// event byte layout and key codes
	localparam int unsigned EVENT_WIDTH = 8;
	localparam int unsigned CODE_WIDTH = 7;
	localparam int unsigned PRESS_BIT = 7;
	localparam logic [6:0] MATRIX_CODE_BASE = 7'h01;
	localparam logic [6:0] ROW_INPUT_BASE = 7'h61;
	localparam logic [6:0] COL_INPUT_BASE = 7'h69;
	// queue and buffer depths
	localparam int unsigned FIFO_DEPTH = 10;
	localparam int unsigned BUFFER_DEPTH = 2;
	// timing
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned DETECT_US = 25;
	localparam int unsigned DETECT_CYCLES = DETECT_US * CLK_MHZ;
	localparam int unsigned SETTLE_CYCLES = 8;
	localparam int unsigned DWELL_CYCLES = 32;
	localparam int unsigned MASK_MAX_S = 31;
	localparam int unsigned SECOND_CYCLES = CLK_MHZ * 1000000;
	localparam int unsigned MASK_WIDTH = 5;
	// register byte offsets
	localparam logic [7:0] OFF_LINE_SELECT = 8'h00;
	localparam logic [7:0] OFF_EVENT_ENABLE = 8'h04;
	localparam logic [7:0] OFF_POLARITY = 8'h08;
	localparam logic [7:0] OFF_EVENT_MODE = 8'h0C;
	localparam logic [7:0] OFF_CONTROL = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	localparam logic [7:0] OFF_EVENT = 8'h18;
	// field positions
	localparam int unsigned CTRL_LOCK_BIT = 0;
	localparam int unsigned CTRL_MASK_LSB = 8;
	localparam int unsigned STAT_COUNT_LSB = 0;
	localparam int unsigned STAT_MASK_BIT = 8;
	// reset values
	localparam logic [17:0] RST_LINES = 18'h00000;
	localparam logic [17:0] RST_POLARITY = 18'h00000;
	localparam logic [4:0] RST_MASK = 5'h00;
endpackage

// ===== verilog/kpe_stream_if.sv
// valid/ready byte stream between encoder stages
`timescale 1ns/100ps
`default_nettype none
interface kpe_stream_if #(
	parameter int unsigned WIDTH = kpe_pkg::EVENT_WIDTH
);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== verilog/kpe_pair_buffer.sv
// small ring buffer that absorbs stalls between encoder and queue
`timescale 1ns/100ps
`default_nettype none
module kpe_pair_buffer #(
	parameter int unsigned DEPTH = kpe_pkg::BUFFER_DEPTH,
	parameter int unsigned WIDTH = kpe_pkg::EVENT_WIDTH
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// stream ports
	kpe_stream_if.snk up_in,
	kpe_stream_if.src down_out
);
	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("buffer depth must be a power of two, at least two");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] rd_ptr;
	logic [PW-1:0] wr_ptr;
	logic [PW:0] count;

	wire take = up_in.valid & up_in.ready;
	wire give = down_out.valid & down_out.ready;

	// ready falls only when truly full, so the encoder stalls instead of dropping
	assign up_in.ready = count != (PW + 1)'(DEPTH);
	assign down_out.valid = count != '0;
	assign down_out.data = mem[rd_ptr];

	always_ff @(posedge ref_clk_in) begin
		if (take) begin
			mem[wr_ptr] <= up_in.data;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			rd_ptr <= '0;
			wr_ptr <= '0;
			count <= '0;
		end else begin
			if (take) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (give) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (take && !give) begin
				count <= count + 1'b1;
			end else if (give && !take) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== verilog/kpe_keypad_event_encoder.sv
// keypad matrix and standalone input event encoder with apb registers
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module kpe_keypad_event_encoder #(
	parameter int unsigned SETTLE_CYCLES = kpe_pkg::SETTLE_CYCLES,
	parameter int unsigned DWELL_CYCLES = kpe_pkg::DWELL_CYCLES,
	parameter int unsigned SECOND_CYCLES = kpe_pkg::SECOND_CYCLES
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// row pins
	input wire logic [kpe_pkg::ROWS-1:0] row_lines_in,
	output logic [kpe_pkg::ROWS-1:0] row_lines_out,
	output logic [kpe_pkg::ROWS-1:0] row_lines_oe_n_out,
	// column pins
	input wire logic [kpe_pkg::COLS-1:0] column_lines_in,
	output logic [kpe_pkg::COLS-1:0] column_lines_out,
	output logic [kpe_pkg::COLS-1:0] column_lines_oe_n_out
);
	localparam int unsigned ROWS = kpe_pkg::ROWS;
	localparam int unsigned COLS = kpe_pkg::COLS;
	localparam int unsigned LINES = kpe_pkg::LINES;
	localparam int unsigned DEPTH = kpe_pkg::FIFO_DEPTH;
	localparam int unsigned DW = $clog2(DWELL_CYCLES);
	localparam int unsigned PRE_W = $clog2(SECOND_CYCLES + 1);
	localparam int unsigned MW = kpe_pkg::MASK_WIDTH;

	// full scan plus synchroniser must fit inside the detection bound
	if (DWELL_CYCLES < SETTLE_CYCLES + COLS || SETTLE_CYCLES < 4 ||
			ROWS * DWELL_CYCLES + 4 > kpe_pkg::DETECT_CYCLES ||
			(DWELL_CYCLES & (DWELL_CYCLES - 1)) != 0) begin : g_bad_scan
		$error("scan timing cannot meet the detection bound");
	end
	if (SECOND_CYCLES < 2 || PRE_W > 31) begin : g_bad_second
		$error("second prescaler out of range");
	end

	// software registers
	logic [LINES-1:0] line_select;
	logic [LINES-1:0] event_enable;
	logic [LINES-1:0] polarity;
	logic [LINES-1:0] input_event_mode;
	logic lock;
	logic [MW-1:0] mask_seconds;

	// input synchronisers
	logic [LINES-1:0] pin_meta;
	logic [LINES-1:0] lvl;

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			pin_meta <= '1;
			lvl <= '1;
		end else begin
			pin_meta <= {column_lines_in, row_lines_in};
			lvl <= pin_meta;
		end
	end

	// matrix scan
	logic [2:0] row_ptr;
	logic [DW-1:0] dwell;
	logic [kpe_pkg::KEYS-1:0] key_state;
	logic [COLS-1:0] row_keys;
	logic [COLS-1:0] col_hit;
	logic [COLS-1:0] m_diff;

	wire row_in_matrix = line_select[row_ptr];
	wire sample_ok = dwell >= DW'(SETTLE_CYCLES);
	wire [6:0] row_base = 7'(row_ptr * COLS);

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			row_ptr <= '0;
			dwell <= '0;
		end else begin
			dwell <= dwell + 1'b1;
			if (dwell == DW'(DWELL_CYCLES - 1)) begin
				row_ptr <= row_ptr + 1'b1;
			end
		end
	end

	always_comb begin
		for (int c = 0; c < COLS; c++) begin
			row_keys[c] = key_state[int'(row_base) + c];
		end
	end

	// a key reads low on its column while its row is pulled low
	assign col_hit = line_select[LINES-1:kpe_pkg::COL_LINE_BASE] & ~lvl[LINES-1:kpe_pkg::COL_LINE_BASE]
		& {COLS{row_in_matrix}};
	assign m_diff = sample_ok ? (col_hit ^ row_keys) : '0;

	// standalone inputs
	logic [LINES-1:0] gpi_state;
	wire [LINES-1:0] gpi_en = event_enable & ~line_select;
	// polarity 1 means active high
	wire [LINES-1:0] active = ~(lvl ^ polarity);
	wire [LINES-1:0] g_diff = gpi_en & (active ^ gpi_state);
	wire [LINES-1:0] g_mute = {LINES{lock}} & input_event_mode;
	wire [LINES-1:0] g_pend = g_diff & ~g_mute;

	// lowest index first; the rest wait a cycle
	logic g_any;
	logic [4:0] g_idx;
	logic m_any;
	logic [3:0] m_idx;

	always_comb begin
		g_any = 1'b0;
		g_idx = '0;
		for (int i = LINES - 1; i >= 0; i--) begin
			if (g_pend[i]) begin
				g_any = 1'b1;
				g_idx = 5'(i);
			end
		end
	end

	always_comb begin
		m_any = 1'b0;
		m_idx = '0;
		for (int i = COLS - 1; i >= 0; i--) begin
			if (m_diff[i]) begin
				m_any = 1'b1;
				m_idx = 4'(i);
			end
		end
	end

	// event assembly: one shared stream for both sources
	kpe_stream_if #(.WIDTH(kpe_pkg::EVENT_WIDTH)) enc_if ();
	kpe_stream_if #(.WIDTH(kpe_pkg::EVENT_WIDTH)) buf_if ();

	// row inputs and column inputs run on in one sequence
	wire [6:0] g_code = kpe_pkg::ROW_INPUT_BASE + 7'(g_idx);
	wire [6:0] m_code = row_base + 7'(m_idx) + kpe_pkg::MATRIX_CODE_BASE;
	wire g_press = active[g_idx];
	wire m_press = col_hit[m_idx];
	wire ev_valid = g_any | m_any;
	wire fire = ev_valid & enc_if.ready;

	assign enc_if.valid = ev_valid;
	// press flag on top, code below
	assign enc_if.data = g_any ? {g_press, g_code} : {m_press, m_code};

	// the state moves on acceptance, or at once for a muted line, so a stall defers, never drops
	genvar gi;
	for (gi = 0; gi < LINES; gi++) begin : g_line
		always_ff @(posedge ref_clk_in) begin
			if (sys_rst_in || !gpi_en[gi]) begin
				gpi_state[gi] <= 1'b0;
			end else if (g_diff[gi] && g_mute[gi]) begin
				gpi_state[gi] <= active[gi];
			end else if (fire && g_any && g_idx == 5'(gi)) begin
				gpi_state[gi] <= active[gi];
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			key_state <= '0;
		end else if (fire && !g_any) begin
			key_state[int'(m_code) - 1] <= m_press;
		end
	end

	kpe_pair_buffer #(
		.DEPTH(kpe_pkg::BUFFER_DEPTH),
		.WIDTH(kpe_pkg::EVENT_WIDTH)
	) u_buffer (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.up_in(enc_if),
		.down_out(buf_if)
	);

	// event queue
	logic [7:0] fifo_mem [DEPTH];
	logic [3:0] head;
	logic [3:0] count;
	logic rd_had_event;

	// five bits wide: head plus count reaches 19 before the wrap
	wire [4:0] tail_raw = {1'b0, head} + {1'b0, count};
	wire [4:0] tail_wrap = tail_raw - 5'(DEPTH);
	wire [3:0] tail = (tail_raw >= 5'(DEPTH)) ? tail_wrap[3:0] : tail_raw[3:0];
	wire [3:0] head_inc = (head == 4'(DEPTH - 1)) ? 4'h0 : head + 4'h1;
	wire push = buf_if.valid & buf_if.ready;
	wire [7:0] head_event = (count != 4'h0) ? fifo_mem[head] : 8'h00;

	assign buf_if.ready = count != 4'(DEPTH);

	// apb decode
	wire setup = psel_in & ~penable_in;
	wire access = psel_in & penable_in;
	wire wr = access & pwrite_in;
	wire hit_sel = paddr_in == kpe_pkg::OFF_LINE_SELECT;
	wire hit_en = paddr_in == kpe_pkg::OFF_EVENT_ENABLE;
	wire hit_pol = paddr_in == kpe_pkg::OFF_POLARITY;
	wire hit_mode = paddr_in == kpe_pkg::OFF_EVENT_MODE;
	wire hit_ctrl = paddr_in == kpe_pkg::OFF_CONTROL;
	wire hit_stat = paddr_in == kpe_pkg::OFF_STATUS;
	wire hit_event = paddr_in == kpe_pkg::OFF_EVENT;
	wire pop = access & ~pwrite_in & hit_event & rd_had_event;

	always_ff @(posedge ref_clk_in) begin
		if (push) begin
			fifo_mem[tail] <= buf_if.data;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			head <= '0;
			count <= '0;
		end else begin
			if (pop) begin
				head <= head_inc;
			end
			if (push && !pop) begin
				count <= count + 4'h1;
			end else if (pop && !push) begin
				count <= count - 4'h1;
			end
		end
	end

	// mask timer, loaded by an event while locked
	logic [MW-1:0] mask_left;
	logic [PRE_W-1:0] prescale;
	wire mask_running = mask_left != '0;

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			mask_left <= '0;
			prescale <= '0;
		end else if (!mask_running) begin
			prescale <= '0;
			if (fire && lock) begin
				mask_left <= mask_seconds;
			end
		end else if (prescale == PRE_W'(SECOND_CYCLES - 1)) begin
			prescale <= '0;
			mask_left <= mask_left - 1'b1;
		end else begin
			prescale <= prescale + 1'b1;
		end
	end

	// register writes take effect at the access edge
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			line_select <= kpe_pkg::RST_LINES;
			event_enable <= kpe_pkg::RST_LINES;
			polarity <= kpe_pkg::RST_POLARITY;
			input_event_mode <= kpe_pkg::RST_LINES;
			lock <= 1'b0;
			mask_seconds <= kpe_pkg::RST_MASK;
		end else if (wr) begin
			if (hit_sel) begin
				line_select <= pwdata_in[LINES-1:0];
			end
			if (hit_en) begin
				event_enable <= pwdata_in[LINES-1:0];
			end
			if (hit_pol) begin
				polarity <= pwdata_in[LINES-1:0];
			end
			if (hit_mode) begin
				input_event_mode <= pwdata_in[LINES-1:0];
			end
			if (hit_ctrl) begin
				lock <= pwdata_in[kpe_pkg::CTRL_LOCK_BIT];
				mask_seconds <= pwdata_in[kpe_pkg::CTRL_MASK_LSB +: MW];
			end
		end
	end

	// read data is captured in the setup cycle and held through access
	logic [31:0] next_prdata;
	logic next_err;

	always_comb begin
		next_prdata = 32'h00000000;
		next_err = 1'b0;
		if (hit_sel) begin
			next_prdata[LINES-1:0] = line_select;
		end else if (hit_en) begin
			next_prdata[LINES-1:0] = event_enable;
		end else if (hit_pol) begin
			next_prdata[LINES-1:0] = polarity;
		end else if (hit_mode) begin
			next_prdata[LINES-1:0] = input_event_mode;
		end else if (hit_ctrl) begin
			next_prdata[kpe_pkg::CTRL_LOCK_BIT] = lock;
			next_prdata[kpe_pkg::CTRL_MASK_LSB +: MW] = mask_seconds;
		end else if (hit_stat) begin
			next_prdata[kpe_pkg::STAT_COUNT_LSB +: 4] = count;
			next_prdata[kpe_pkg::STAT_MASK_BIT] = mask_running;
		end else if (hit_event) begin
			next_prdata[7:0] = head_event;
		end else begin
			next_err = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			prdata_out <= 32'h00000000;
			pslverr_out <= 1'b0;
			rd_had_event <= 1'b0;
		end else if (setup) begin
			prdata_out <= pwrite_in ? 32'h00000000 : next_prdata;
			pslverr_out <= next_err;
			rd_had_event <= count != 4'h0;
		end
	end

	assign pready_out = 1'b1;

	// pin drive: only the scanned matrix row is pulled low
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			row_lines_oe_n_out <= '1;
		end else begin
			for (int r = 0; r < ROWS; r++) begin
				row_lines_oe_n_out[r] <= ~(line_select[r] && row_ptr == 3'(r));
			end
		end
	end

	assign row_lines_out = '0;
	assign column_lines_out = '0;
	assign column_lines_oe_n_out = '1;
endmodule
`default_nettype wire

// ===== verilog/kpe_done.sv
// intentionally empty design unit list end
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ===== test/kpe_props.sv
// pin and register bus checks for the keypad event encoder
`timescale 1ns/100ps
`default_nettype none
module kpe_props (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	// pins
	input wire logic [7:0] row_lines_in,
	input wire logic [7:0] row_lines_out,
	input wire logic [7:0] row_lines_oe_n_out,
	input wire logic [9:0] column_lines_in,
	input wire logic [9:0] column_lines_out,
	input wire logic [9:0] column_lines_oe_n_out
);
	logic [17:0] sel_q;
	logic [7:0] sel_d;
	logic [7:0] sel_e;
	wire setup = psel_in && !penable_in;
	wire rd_stat = setup && !pwrite_in && paddr_in == kpe_pkg::OFF_STATUS;
	wire rd_evt = setup && !pwrite_in && paddr_in == kpe_pkg::OFF_EVENT;
	wire sel_wr = psel_in && penable_in && pwrite_in && paddr_in == kpe_pkg::OFF_LINE_SELECT;
	// shadow of the matrix selection, delayed twice to allow for the registered drive
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			sel_q <= 18'h00000;
			sel_d <= 8'h00;
			sel_e <= 8'h00;
		end else begin
			if (sel_wr) begin
				sel_q <= pwdata_in[17:0];
			end
			sel_d <= sel_q[7:0];
			sel_e <= sel_d;
		end
	end
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);
	ready_always_a: assert property (pready_out)
		else $error("pready low");
	err_decode_a: assert property (setup |=> pslverr_out ==
		($past(paddr_in) > 8'h18 || $past(paddr_in[1:0]) != 2'h0))
		else $error("error flag does not match address decode");
	event_code_a: assert property (rd_evt |=> prdata_out[31:8] == 24'h000000 &&
		(prdata_out[6:0] inside {[7'h01:7'h50], [7'h61:7'h72]} || prdata_out[7:0] == 8'h00))
		else $error("event byte outside the code table");
	status_count_a: assert property (rd_stat |=> prdata_out[3:0] <= 4'hA &&
		prdata_out[7:4] == 4'h0 && prdata_out[31:9] == 23'h000000)
		else $error("queue count out of range");
	one_row_a: assert property ($onehot0(~row_lines_oe_n_out))
		else $error("more than one row driven");
	row_sel_a: assert property ((~row_lines_oe_n_out & ~(sel_q[7:0] | sel_d | sel_e)) == 8'h00)
		else $error("unselected row driven");
	// a row entered from idle may start mid-dwell, so only row-to-row steps are timed
	row_dwell_a: assert property (($changed(row_lines_oe_n_out) && row_lines_oe_n_out != 8'hFF
		&& $past(row_lines_oe_n_out) != 8'hFF) |=> $stable(row_lines_oe_n_out)[*7])
		else $error("row drive too short");
	col_undriven_a: assert property (column_lines_oe_n_out == 10'h3FF && column_lines_out == 10'h000)
		else $error("column driven");
	row_level_a: assert property (row_lines_out == 8'h00)
		else $error("row drive level not low");
endmodule
bind kpe_keypad_event_encoder kpe_props u_props (
	.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
	.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
	.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
	.pslverr_out(pslverr_out), .row_lines_in(row_lines_in), .row_lines_out(row_lines_out),
	.row_lines_oe_n_out(row_lines_oe_n_out), .column_lines_in(column_lines_in),
	.column_lines_out(column_lines_out), .column_lines_oe_n_out(column_lines_oe_n_out)
);
`default_nettype wire

// ===== test/kpe_keypad_model.sv
// switch matrix and standalone buttons, each line resting at its level_in bit
`timescale 1ns/100ps
`default_nettype none
module kpe_keypad_model (
	// scanner drive
	input wire logic [7:0] row_drv_in,
	input wire logic [7:0] row_oe_n_in,
	// switches
	input wire logic [79:0] key_down_in,
	input wire logic [17:0] level_in,
	// pin levels
	output logic [7:0] row_lvl_out,
	output logic [9:0] col_lvl_out
);
	// a closed key pulls its column low only while its row line reads low
	always_comb begin
		row_lvl_out = level_in[7:0] & (row_drv_in | row_oe_n_in);
		for (int c = 0; c < 10; c++) begin
			col_lvl_out[c] = level_in[8+c];
			for (int r = 0; r < 8; r++) begin
				if (key_down_in[r*10+c] && !row_lvl_out[r]) begin
					col_lvl_out[c] = 1'b0;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== test/kpe_keypad_event_encoder_tb.sv
// self-checking bench for the keypad event encoder
`timescale 1ns/100ps
`default_nettype none
module kpe_keypad_event_encoder_tb;
	logic clk, rst, psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [79:0] key_down;
	logic [17:0] lvl;
	wire [31:0] prdata;
	wire pready, pslverr;
	wire [7:0] row_lvl, row_out, row_oe_n;
	wire [9:0] col_lvl, col_out, col_oe_n;
	int err_total, tests_run;
	kpe_keypad_event_encoder #(.SECOND_CYCLES(100)) dut_u (
		.ref_clk_in(clk), .sys_rst_in(rst), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .row_lines_in(row_lvl),
		.row_lines_out(row_out), .row_lines_oe_n_out(row_oe_n), .column_lines_in(col_lvl),
		.column_lines_out(col_out), .column_lines_oe_n_out(col_oe_n)
	);
	kpe_keypad_model pad_u (
		.row_drv_in(row_out), .row_oe_n_in(row_oe_n), .key_down_in(key_down),
		.level_in(lvl), .row_lvl_out(row_lvl), .col_lvl_out(col_lvl)
	);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one apb transfer, then an idle cycle so the next call starts on a fresh edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic expect_rd(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		check(what, q, exp);
	endtask
	// polls the queue count; the bound stays inside the 25 us detection limit
	task automatic wait_cnt(input logic [3:0] n);
		logic [31:0] q;
		logic e;
		int k;
		k = 0;
		do begin
			apb(1'b0, kpe_pkg::OFF_STATUS, 32'h0, q, e);
			k++;
		end while (q[3:0] !== n && k < 830);
		check("count", {28'h0, q[3:0]}, {28'h0, n});
	endtask
	task automatic pop(input logic press, input logic [6:0] c);
		expect_rd("event", kpe_pkg::OFF_EVENT, {24'h0, press, c});
	endtask
	function automatic logic [6:0] code(input int i);
		return (i < 8) ? kpe_pkg::ROW_INPUT_BASE + 7'(i) : kpe_pkg::COL_INPUT_BASE + 7'(i - 8);
	endfunction
	initial begin
		logic [31:0] q;
		logic e;
		int keys[3];
		keys = '{0, 31, 79};
		{psel, penable, pwrite, paddr, pwdata} = '0;
		key_down = '0;
		lvl = 18'h3FF00;
		rst = 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		expect_rd("select", kpe_pkg::OFF_LINE_SELECT, {14'h0, kpe_pkg::RST_LINES});
		expect_rd("polarity", kpe_pkg::OFF_POLARITY, {14'h0, kpe_pkg::RST_POLARITY});
		wr(kpe_pkg::OFF_STATUS, 32'hFFFFFFFF);
		expect_rd("status", kpe_pkg::OFF_STATUS, 32'h0);
		pop(1'b0, 7'h00);
		apb(1'b0, 8'h1C, 32'h0, q, e);
		check("unmapped err", {31'h0, e}, 32'h1);
		check("unmapped data", q, 32'h0);
		$display("test reset done");
		wr(kpe_pkg::OFF_POLARITY, 32'h000FF);
		wr(kpe_pkg::OFF_EVENT_ENABLE, 32'h3FFFF);
		for (int i = 0; i < 18; i++) begin
			lvl[i] <= (i < 8);
			wait_cnt(4'h1);
			pop(1'b1, code(i));
			lvl[i] <= (i >= 8);
			wait_cnt(4'h1);
			pop(1'b0, code(i));
		end
		$display("test standalone done");
		lvl <= 18'h3C0FF;
		wait_cnt(4'hA);
		repeat (20) @(posedge clk);
		expect_rd("full", kpe_pkg::OFF_STATUS, 32'hA);
		for (int i = 0; i < 14; i++) pop(1'b1, code(i));
		lvl <= 18'h3FF00;
		wait_cnt(4'hA);
		for (int i = 0; i < 14; i++) pop(1'b0, code(i));
		pop(1'b0, 7'h00);
		$display("test queue done");
		wr(kpe_pkg::OFF_EVENT_MODE, 32'h1);
		wr(kpe_pkg::OFF_CONTROL, 32'h1F01);
		expect_rd("mask max", kpe_pkg::OFF_CONTROL, 32'h1F01);
		wr(kpe_pkg::OFF_CONTROL, 32'h0201);
		lvl[0] <= 1'b1;
		repeat (50) @(posedge clk);
		expect_rd("locked", kpe_pkg::OFF_STATUS, 32'h0);
		lvl[0] <= 1'b0;
		lvl[1] <= 1'b1;
		wait_cnt(4'h1);
		expect_rd("mask on", kpe_pkg::OFF_STATUS, 32'h101);
		pop(1'b1, code(1));
		repeat (400) @(posedge clk);
		expect_rd("mask off", kpe_pkg::OFF_STATUS, 32'h0);
		wr(kpe_pkg::OFF_CONTROL, 32'h0);
		lvl[1] <= 1'b0;
		wait_cnt(4'h1);
		pop(1'b0, code(1));
		wr(kpe_pkg::OFF_EVENT_ENABLE, 32'h3FFFB);
		lvl[2] <= 1'b1;
		repeat (50) @(posedge clk);
		expect_rd("unused line", kpe_pkg::OFF_STATUS, 32'h0);
		$display("test lock done");
		wr(kpe_pkg::OFF_EVENT_ENABLE, 32'h0);
		lvl <= 18'h3FFFF;
		wr(kpe_pkg::OFF_LINE_SELECT, 32'h3FFFF);
		foreach (keys[j]) begin
			key_down[keys[j]] <= 1'b1;
			wait_cnt(4'h1);
			pop(1'b1, kpe_pkg::MATRIX_CODE_BASE + 7'(keys[j]));
			key_down[keys[j]] <= 1'b0;
			wait_cnt(4'h1);
			pop(1'b0, kpe_pkg::MATRIX_CODE_BASE + 7'(keys[j]));
		end
		$display("test matrix done");
		finish_test();
	end
	// the run needs well under 30000 cycles
	initial begin
		repeat (100000) @(posedge clk);
		$display("watchdog expired");
		err_total++;
		finish_test();
	end
endmodule
`default_nettype wire
